//--- src/ecd_params.svh
// Purpose: constants for the error-correction unit sequencer
// Assumes: mode codes are {write_read_select, mode1, complement_select}
// Notes:   strobe widths counted in 100 MHz cycles
`ifndef ECD_PARAMS_SVH
`define ECD_PARAMS_SVH
// mode codes, 3 bits: mode number on the unit's mode-select pins
`define ECD_MODE_NORM_WRITE  3'h0
`define ECD_MODE_CMPL_WRITE  3'h1
`define ECD_MODE_DATA_TO_SYN 3'h2
`define ECD_MODE_LOW_WRITE   3'h3
`define ECD_MODE_NORM_READ   3'h4
`define ECD_MODE_CMPL_READ   3'h5
`define ECD_MODE_MONITOR     3'h6
`define ECD_MODE_PASS        3'h7
// latch strobe settle time, in ns, and the cycle count derived from it
`define ECD_SETTLE_NS        60
`define ECD_CLK_NS           10
`define ECD_SETTLE_CYC       ((`ECD_SETTLE_NS + `ECD_CLK_NS - 1) / `ECD_CLK_NS)
`define ECD_CNT_W            4
// flag patterns after complement read {any, one, zero}
`define ECD_FLAGS_TWO_HARD   3'h0
`define ECD_FLAGS_SOFT_CHK   3'h6
`define ECD_FLAGS_SOFT_DATA  3'h7
`define ECD_FLAGS_UNCORR     3'h4
`define ECD_ALL_ONES         16'hFFFF
`define ECD_ZERO_WORD        16'h0000
`define ECD_ZERO_SYN         8'h00
`endif

//--- src/ecd_pkg.sv
// Purpose: types for the error-correction unit sequencer
// Assumes: nothing beyond the params header
// Notes:   one-hot states, commands
package ecd_pkg;
   typedef enum logic [3:0] {
      ECD_CMD_IDLE     = 4'h0,
      ECD_CMD_DEC      = 4'h1, // double-error complement recovery
      ECD_CMD_DATA_SYN = 4'h2, // data bus to syndrome bus
      ECD_CMD_SYN_DATA = 4'h3, // syndrome bus to data bus (6B)
      ECD_CMD_INJECT   = 4'h4, // diagnostic check bits to memory
      ECD_CMD_SELFTEST = 4'h5, // on-card self test
      ECD_CMD_MONITOR  = 4'h6, // monitor syndromes (6A)
      ECD_CMD_CLEAR    = 4'h7, // clear syndrome latch (7A)
      ECD_CMD_INIT     = 4'h8  // power-up zero write
   } ecd_cmd_t;
   typedef enum logic [6:0] {
      ECD_ST_IDLE  = 7'h01,
      ECD_ST_SETUP = 7'h02,
      ECD_ST_LATCH = 7'h04,
      ECD_ST_OPEN  = 7'h08,
      ECD_ST_HOLD  = 7'h10,
      ECD_ST_NEXT  = 7'h20,
      ECD_ST_DONE  = 7'h40
   } ecd_state_t;
endpackage

//--- src/ecd_pin_if.sv
// Purpose: pin-level strobe bundle between sequencer and timer
// Assumes: single clock
// Notes:   timer counts the settle time of each latch step
`timescale 1ns/100ps
`default_nettype none
interface ecd_pin_if;
   logic start;
   logic expired;
   modport seq (output start, input expired);
   modport tmr (input start, output expired);
endinterface
`default_nettype wire

//--- src/ecd_timer.sv
// Purpose: settle timer for each latch step
// Assumes: start is a one-cycle pulse
// Notes:   expired pulses once the settle count has run out
`timescale 1ns/100ps
`default_nettype none
`include "ecd_params.svh"
module ecd_timer
   import ecd_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   ecd_pin_if.tmr     tif
);
   logic [`ECD_CNT_W-1:0] cnt_r;
   logic                  run_r;
   logic                  exp_r;
   wire                   last = (cnt_r == `ECD_CNT_W'(`ECD_SETTLE_CYC - 1));
   // -------------------------------------------------------------
   // settle counter
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else begin
         exp_r <= run_r && last;
         if (tif.start) begin
            cnt_r <= '0;
            run_r <= 1'b1;
         end else if (run_r) begin
            cnt_r <= cnt_r + `ECD_CNT_W'(1);
            run_r <= !last;
         end
      end
   end
   assign tif.expired = exp_r;
endmodule
`default_nettype wire

//--- src/ecd_host.sv
// Purpose: controller that drives the error-correction unit's pins
// Assumes: unit data and syndrome latches are transparent low, capture on rise; check latch is transparent high
// Notes:   strobes are held a settle time per step
//
// Function
// - after double error: complement select high, write, both byte enables low
// - after complement read, corrected word goes to rd_data; memory keeps the complement
// - repeat data-to-syndrome while data latch enable stays low
// - controller keeps syndrome input latch at zero in 16-bit use
// - clear: mode 7 with check/syndrome latch enable low; syndrome bus never driven
`timescale 1ns/100ps
`default_nettype none
`include "ecd_params.svh"
module ecd_host
   import ecd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // user side
   input  wire logic        cmd_valid,
   input  wire ecd_cmd_t    cmd,
   input  wire logic [15:0] cmd_data,
   output logic             cmd_ready,
   output logic             done,
   output logic [15:0]      rd_data,
   output logic [2:0]       rd_flags,
   output logic             uncorrectable,
   // unit pins
   output logic [2:0]       mode_sel,
   output logic             data_latch_enable,
   output logic             check_syndrome_latch_enable,
   output logic             output_latch_enable_n,
   output logic             lower_byte_output_enable_n,
   output logic             upper_byte_output_enable_n,
   output logic             syndrome_output_enable_n,
   output logic             mem_write,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic             dq_oe,
   input  wire logic [7:0]  syn_in,
   output logic [7:0]       syn_out,
   output logic             syn_oe,
   input  wire logic        any_error_flag,
   input  wire logic        error_one_flag,
   input  wire logic        error_zero_flag
);
   ecd_pin_if pif ();
   ecd_timer u_timer (.clk(clk), .rst_n(rst_n), .tif(pif));

   ecd_state_t        st_r, st_nxt;
   ecd_cmd_t          cmd_r;
   logic              phase_r;          // second pass of two-pass commands
   logic [15:0]       wdata_r;
   logic [2:0]        mode_r, mode_nxt;
   logic              dle_r, check_syndrome_latch_enable_r, ole_n_r, ob0_n_r, ob1_n_r, oes_n_r, wr_r;
   logic              dq_oe_r, syn_oe_r, rdy_r, done_r, unc_r;
   logic [15:0]       dq_out_r, rd_r;
   logic [7:0]        syn_out_r;
   logic [2:0]        flg_r;
   // three-stage input samplers
   logic [15:0]       dq_s1, dq_s2, dq_s3, dq_f;
   logic [2:0]        fl_s1, fl_s2, fl_s3, fl_f;
   wire               dq_stable = (dq_s2 == dq_s3);
   wire  [2:0]        flags_now = fl_f;

   // -------------------------------------------------------------
   // mode choice per command and pass
   // -------------------------------------------------------------
   always_comb begin
      case (cmd_r)
         ECD_CMD_DEC:      mode_nxt = phase_r ? `ECD_MODE_CMPL_READ
                                              : `ECD_MODE_CMPL_WRITE;
         ECD_CMD_DATA_SYN: mode_nxt = `ECD_MODE_DATA_TO_SYN;
         ECD_CMD_INJECT:   mode_nxt = `ECD_MODE_DATA_TO_SYN;
         ECD_CMD_SELFTEST: mode_nxt = phase_r ? `ECD_MODE_NORM_READ
                                              : `ECD_MODE_DATA_TO_SYN;
         ECD_CMD_SYN_DATA: mode_nxt = `ECD_MODE_MONITOR;
         ECD_CMD_MONITOR:  mode_nxt = `ECD_MODE_MONITOR;
         ECD_CMD_CLEAR:    mode_nxt = `ECD_MODE_PASS;
         default:          mode_nxt = `ECD_MODE_NORM_WRITE;
      endcase
   end

   wire two_pass = (cmd_r == ECD_CMD_DEC) || (cmd_r == ECD_CMD_SELFTEST);
   wire dil_open = two_pass && phase_r;  // memory or host word into data latch
   wire is_read  = (mode_r == `ECD_MODE_CMPL_READ) || (mode_r == `ECD_MODE_NORM_READ) ||
                   (cmd_r == ECD_CMD_SYN_DATA) || (cmd_r == ECD_CMD_MONITOR);
   // syndrome enable low except for the 6B read-out, keeps syndrome latch clear
   wire oes_low  = (cmd_r != ECD_CMD_SYN_DATA);
   // host drives dq for mode 2 loads and both self-test passes
   wire host_dq  = (mode_r == `ECD_MODE_DATA_TO_SYN) || (cmd_r == ECD_CMD_SELFTEST);
   // write pulse for complement write, injection, init; masked in read modes, so no write-back
   wire do_write = (cmd_r == ECD_CMD_DEC) || (cmd_r == ECD_CMD_INJECT) ||
                   (cmd_r == ECD_CMD_INIT);
   wire byte_drv = do_write || (cmd_r == ECD_CMD_SYN_DATA) || (cmd_r == ECD_CMD_MONITOR);

   // -------------------------------------------------------------
   // sequence state machine
   // -------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ECD_ST_IDLE:  if (cmd_valid && cmd != ECD_CMD_IDLE) st_nxt = ECD_ST_SETUP;
         ECD_ST_SETUP: if (pif.expired) st_nxt = ECD_ST_LATCH;
         ECD_ST_LATCH: if (pif.expired) st_nxt = ECD_ST_OPEN;
         ECD_ST_OPEN:  if (pif.expired && dq_stable) st_nxt = ECD_ST_HOLD;
         ECD_ST_HOLD:  if (pif.expired) st_nxt = (two_pass && !phase_r) ? ECD_ST_NEXT
                                                                     : ECD_ST_DONE;
         ECD_ST_NEXT:  st_nxt = ECD_ST_SETUP;
         ECD_ST_DONE:  st_nxt = ECD_ST_IDLE;
         default:      st_nxt = ECD_ST_IDLE;
      endcase
   end
   // re-arm the timer while the bus is still moving at the open step
   assign pif.start = ((st_r != st_nxt) && (st_nxt != ECD_ST_IDLE) &&
                       (st_nxt != ECD_ST_DONE) && (st_nxt != ECD_ST_NEXT)) ||
                      ((st_r == ECD_ST_OPEN) && pif.expired && !dq_stable);

   // -------------------------------------------------------------
   // input samplers
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1 <= '0; dq_s2 <= '0; dq_s3 <= '0; dq_f <= '0;
         fl_s1 <= '0; fl_s2 <= '0; fl_s3 <= '0; fl_f <= '0;
      end else begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         dq_s3 <= dq_s2;
         if (dq_stable) dq_f <= dq_s3;
         fl_s1 <= {any_error_flag, error_one_flag, error_zero_flag};
         fl_s2 <= fl_s1;
         fl_s3 <= fl_s2;
         if (fl_s2 == fl_s3) fl_f <= fl_s3;
      end
   end

   // -------------------------------------------------------------
   // state, command capture
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= ECD_ST_IDLE;
         cmd_r   <= ECD_CMD_IDLE;
         phase_r <= 1'b0;
         wdata_r <= `ECD_ZERO_WORD;
         mode_r  <= `ECD_MODE_NORM_WRITE;
      end else begin
         st_r <= st_nxt;
         if (st_r == ECD_ST_IDLE && st_nxt == ECD_ST_SETUP) begin
            cmd_r   <= cmd;
            phase_r <= 1'b0;
            wdata_r <= (cmd == ECD_CMD_DATA_SYN) ? cmd_data : cmd_data;
         end
         if (st_r == ECD_ST_NEXT) phase_r <= 1'b1;
         if (st_r == ECD_ST_SETUP) mode_r <= mode_nxt;
      end
   end

   // -------------------------------------------------------------
   // pin strobes, per step
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dle_r <= 1'b1; check_syndrome_latch_enable_r <= 1'b1; ole_n_r <= 1'b1;
         ob0_n_r <= 1'b1; ob1_n_r <= 1'b1;
         oes_n_r <= 1'b0;
         wr_r <= 1'b0; dq_oe_r <= 1'b0; syn_oe_r <= 1'b0;
         dq_out_r <= `ECD_ZERO_WORD; syn_out_r <= `ECD_ZERO_SYN;
      end else begin
         wr_r     <= 1'b0;
         syn_oe_r <= 1'b0;
         syn_out_r <= `ECD_ZERO_SYN;
         case (st_r)
            ECD_ST_SETUP: begin
               // data for mode 2: the captured cmd_data word; all ones keeps generated checks zero
               dq_oe_r  <= host_dq;
               dq_out_r <= (cmd_r == ECD_CMD_DATA_SYN) ? wdata_r : wdata_r;
               oes_n_r  <= !oes_low;
               // second passes open the data latch here, ECD_CMD_DATA_SYN at the latch step; power-up zeros stay put
               dle_r    <= !dil_open;
               check_syndrome_latch_enable_r   <= !(cmd_r == ECD_CMD_CLEAR ||
                             (cmd_r == ECD_CMD_SELFTEST && phase_r));
            end
            ECD_ST_LATCH: begin
               // capture: data and syndrome latches on rising enable, check latch on falling enable
               check_syndrome_latch_enable_r <= !(cmd_r == ECD_CMD_SELFTEST || cmd_r == ECD_CMD_INJECT);
               dle_r <= (cmd_r == ECD_CMD_DATA_SYN) ? 1'b0 : 1'b1;
            end
            ECD_ST_OPEN: begin
               ole_n_r <= 1'b0;
               ob0_n_r <= !byte_drv;
               ob1_n_r <= !byte_drv;
               if (byte_drv) dq_oe_r <= 1'b0;
            end
            ECD_ST_HOLD: begin
               ole_n_r <= 1'b1;
               wr_r    <= do_write && !is_read;
            end
            default: begin
               ob0_n_r <= 1'b1;
               ob1_n_r <= 1'b1;
               dq_oe_r <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // results: read word, flags, verdict
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_r <= `ECD_ZERO_WORD; flg_r <= 3'h0;
         unc_r <= 1'b0; done_r <= 1'b0; rdy_r <= 1'b0;
      end else begin
         done_r <= (st_r == ECD_ST_DONE);
         rdy_r  <= (st_nxt == ECD_ST_IDLE);
         if (st_r == ECD_ST_HOLD && pif.expired) begin
            rd_r  <= dq_f;
            flg_r <= flags_now;
            unc_r <= (mode_r == `ECD_MODE_CMPL_READ) &&
                     (flags_now == `ECD_FLAGS_UNCORR);
         end
      end
   end

   assign mode_sel                    = mode_r;
   assign data_latch_enable           = dle_r;
   assign check_syndrome_latch_enable = check_syndrome_latch_enable_r;
   assign output_latch_enable_n       = ole_n_r;
   assign lower_byte_output_enable_n  = ob0_n_r;
   assign upper_byte_output_enable_n  = ob1_n_r;
   assign syndrome_output_enable_n    = oes_n_r;
   assign mem_write                   = wr_r;
   assign dq_out                      = dq_out_r;
   assign dq_oe                       = dq_oe_r;
   assign syn_out                     = syn_out_r;
   assign syn_oe                      = syn_oe_r;
   assign cmd_ready                   = rdy_r;
   assign done                        = done_r;
   assign rd_data                     = rd_r;
   assign rd_flags                    = flg_r;
   assign uncorrectable               = unc_r;
endmodule
`default_nettype wire

//--- tb/ecd_host_checker.sv
// Purpose: port-level checks on the unit sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every ecd_host instance
`timescale 1ns/100ps
`default_nettype none
`include "ecd_params.svh"
module ecd_chk
   import ecd_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       cmd_valid,
   input wire ecd_cmd_t   cmd,
   input wire logic       cmd_ready,
   input wire logic       done,
   input wire logic [2:0] rd_flags,
   input wire logic       uncorrectable,
   input wire logic [2:0] mode_sel,
   input wire logic       output_latch_enable_n,
   input wire logic       lower_byte_output_enable_n,
   input wire logic       upper_byte_output_enable_n,
   input wire logic       syndrome_output_enable_n,
   input wire logic       mem_write,
   input wire logic       dq_oe,
   input wire logic       syn_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // complement write step, then complement read step
   sequence s_cmpl_wr;
      (mode_sel == 3'h1) && mem_write;
   endsequence
   sequence s_cmpl_rd;
      ##[1:200] (mode_sel == 3'h5);
   endsequence
   wire take = cmd_valid && cmd_ready && (cmd != ECD_CMD_IDLE);
   AST_DONE_PULSE: assert property (done |=> !done) else $error("done too long");
   AST_TAKE: assert property (take |=> !cmd_ready) else $error("still ready");
   AST_BUSY_BOUND: assert property (take |-> ##[8:600] done) else $error("no done");
   AST_READY_BACK: assert property (done |-> ##[0:2] cmd_ready) else $error("not ready");
   AST_UNCORR: assert property (uncorrectable |-> rd_flags == `ECD_FLAGS_UNCORR)
      else $error("uncorrectable without flags 100");
   AST_CMPL_SEQ: assert property (s_cmpl_wr |-> s_cmpl_rd) else $error("no cmpl read");
   AST_WRITE_BYTES: assert property (mem_write |-> !lower_byte_output_enable_n
      && !upper_byte_output_enable_n) else $error("write with bytes off");
   AST_WRITE_MODE: assert property (mem_write |-> !mode_sel[2]) else $error("write in read");
   AST_NO_FIGHT: assert property (dq_oe |-> lower_byte_output_enable_n
      && upper_byte_output_enable_n) else $error("dq driven by both");
   AST_SYN_QUIET: assert property (!syn_oe) else $error("syndrome bus driven");
   AST_OES_CLEAR: assert property ((mode_sel != 3'h6 && $past(mode_sel) != 3'h6)
      |-> !syndrome_output_enable_n) else $error("syndrome enable high");
   AST_OPEN_STABLE: assert property ($fell(output_latch_enable_n) |-> $stable(mode_sel))
      else $error("mode moved at open");
endmodule
bind ecd_host ecd_chk chk_u (.clk, .rst_n, .cmd_valid, .cmd, .cmd_ready, .done, .rd_flags,
   .uncorrectable, .mode_sel, .output_latch_enable_n, .lower_byte_output_enable_n,
   .upper_byte_output_enable_n, .syndrome_output_enable_n, .mem_write, .dq_oe, .syn_oe);
`default_nettype wire

//--- tb/ecd_dev_model.sv
// Purpose: behavioural model of the correction unit
// Assumes: data and syndrome latches transparent while enable low, check latch while high
// Notes:   flags come from flag_set; own check matrix
`timescale 1ns/100ps
`default_nettype none
module ecd_dev_model (
   input  wire logic        pwr_n,
   input  wire logic [2:0]  mode_sel,
   input  wire logic        data_latch_enable,
   input  wire logic        check_syndrome_latch_enable,
   input  wire logic        output_latch_enable_n,
   input  wire logic        lower_byte_output_enable_n,
   input  wire logic        upper_byte_output_enable_n,
   input  wire logic        syndrome_output_enable_n,
   input  wire logic [15:0] dq,
   input  wire logic [2:0]  flag_set,
   output logic [15:0]      dev_dq,
   output logic             dev_oe,
   output logic [7:0]       syn_pins,
   output logic [2:0]       flags
);
   logic [15:0] dil_r, dol_r;
   logic [7:0]  cil_r, sil_r;
   logic [1:0]  ef_r;
   // mode decode and generated syndrome
   wire         cmpl = (mode_sel == 3'h1) || (mode_sel == 3'h5);
   wire         rd   = mode_sel[2] && (mode_sel != 3'h6);
   wire  [6:0]  sg   = cil_r[6:0] ^ ~(dil_r[14:8] & dil_r[6:0]) ^ sil_r[6:0];
   // data and syndrome input latches, cleared at power-up
   always_latch begin
      if (!pwr_n) begin
         dil_r <= 16'h0000;
         sil_r <= 8'h00;
      end else begin
         if (!data_latch_enable && !dev_oe && mode_sel != 3'h2) dil_r <= dq;
         if (!check_syndrome_latch_enable && mode_sel == 3'h7) sil_r <= 8'h00;
         else if (!check_syndrome_latch_enable && syndrome_output_enable_n) sil_r <= 8'hA5;
      end
   end
   always_latch if (check_syndrome_latch_enable && mode_sel == 3'h2) cil_r <= dq[15:8];
   always_latch if (!output_latch_enable_n) dol_r <= cmpl ? ~dil_r : dil_r;
   always_latch if (rd) ef_r <= flag_set[1:0];
   // pin drive
   assign flags    = rd ? flag_set : 3'h0;
   assign dev_oe   = !lower_byte_output_enable_n || !upper_byte_output_enable_n;
   assign dev_dq   = (mode_sel == 3'h6) ? {ef_r[0], cil_r[6:0], ef_r[1],
                     syndrome_output_enable_n ? sil_r[6:0] : sg} : dol_r;
   assign syn_pins = syndrome_output_enable_n ? ~{1'b0, sg} : {1'b0, sg};
endmodule
`default_nettype wire

//--- tb/tb_ecd_host.sv
// Purpose: self-checking bench for the unit sequencer
// Assumes: model stands in for the unit, one-word memory here
// Notes:   mode steps logged at each fall of output_latch_enable_n
`timescale 1ns/100ps
`default_nettype none
module tb_ecd_host
   import ecd_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, ole_q = 1'b1;
   ecd_cmd_t    cmd = ECD_CMD_IDLE;
   logic [15:0] cmd_data = 16'h0000, mem_r = 16'h3C5A, dq_last = 16'h0000, seq = 16'h0000;
   logic [15:0] word_e = 16'h0000;
   logic [15:0] rd_data, dq_out, dq_in, dev_dq;
   logic [2:0]  rd_flags, mode_sel, dev_flags, flag_set = 3'h0;
   logic [7:0]  syn_out, syn_in;
   logic        cmd_ready, done, uncorrectable, data_latch_enable, check_syndrome_latch_enable;
   logic        output_latch_enable_n, lower_byte_output_enable_n, upper_byte_output_enable_n;
   logic        syndrome_output_enable_n, mem_write, dq_oe, syn_oe, dev_oe;
   logic [2:0]  pats [4] = '{3'h0, 3'h7, 3'h4, 3'h6};
   int          n_fail = 0, n_compared = 0;
   always #5 clk = ~clk;
   // bus: host, unit, memory on reads, else inverse of the last driven word
   wire         mem_drv = mode_sel[2] && !data_latch_enable;
   wire         bus_drv = dq_oe || dev_oe || mem_drv;
   assign dq_in = dq_oe ? dq_out : dev_oe ? dev_dq : mem_drv ? mem_r : ~dq_last;
   always @(posedge clk) begin
      if (bus_drv) dq_last <= dq_in;
      ole_q   <= output_latch_enable_n;
      if (mem_write) mem_r <= dq_in;
      if (ole_q && !output_latch_enable_n) seq <= {seq[11:0], 1'b0, mode_sel};
   end
   ecd_host dut_u (.clk, .rst_n, .cmd_valid, .cmd, .cmd_data, .cmd_ready, .done, .rd_data,
      .rd_flags, .uncorrectable, .mode_sel, .data_latch_enable, .check_syndrome_latch_enable,
      .output_latch_enable_n, .lower_byte_output_enable_n, .upper_byte_output_enable_n,
      .syndrome_output_enable_n, .mem_write, .dq_in, .dq_out, .dq_oe, .syn_in, .syn_out,
      .syn_oe, .any_error_flag(dev_flags[2]), .error_one_flag(dev_flags[1]),
      .error_zero_flag(dev_flags[0]));
   ecd_dev_model dev_u (.pwr_n(rst_n), .mode_sel, .data_latch_enable,
      .check_syndrome_latch_enable, .output_latch_enable_n, .lower_byte_output_enable_n,
      .upper_byte_output_enable_n, .syndrome_output_enable_n, .dq(dq_in), .flag_set,
      .dev_dq, .dev_oe, .syn_pins(syn_in), .flags(dev_flags));
   // compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one command, a refused second request while busy
   task automatic run(input ecd_cmd_t c, input logic [15:0] d, input logic [15:0] e);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 50) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 50) begin
         n_fail++;
         $display("[FAIL] cmd_ready expected 1 seen %b", cmd_ready);
      end
      seq = 16'h000F;
      cmd_valid = 1'b1;
      cmd = c;
      cmd_data = d;
      repeat (10) begin
         @(posedge clk);
         #1;
         cmd = ECD_CMD_CLEAR;
      end
      cmd_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 1000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 1000) begin
         n_fail++;
         $display("[FAIL] done expected 1 seen %b", done);
      end
      chk("mode steps", e, seq);
      $display("test %s ended", c.name());
   endtask
   task automatic close_out;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      $display("[FAIL] watchdog expected done seen hang");
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk("oes_n", 16'h0000, 16'(syndrome_output_enable_n));
      chk("ole_n", 16'h0001, 16'(output_latch_enable_n));
      rst_n = 1'b1;
      run(ECD_CMD_INIT, 16'h0000, 16'h00F0);
      chk("zero word", 16'h0000, mem_r);
      foreach (pats[i]) begin
         flag_set = pats[i];
         mem_r = 16'h3C5A;
         run(ECD_CMD_DEC, 16'h0000, 16'h0F15);
         chk("flags", 16'(pats[i]), 16'(rd_flags));
         chk("uncorr", 16'(pats[i] == 3'h4), 16'(uncorrectable));
         chk("cmpl write", ~word_e, mem_r);
         chk("corrected", word_e, rd_data);
         word_e = ~word_e;
      end
      run(ECD_CMD_SELFTEST, 16'hA55A, 16'h0F24);
      run(ECD_CMD_MONITOR, 16'h0000, 16'h00F6);
      chk("check byte", 16'h0025, 16'(rd_data[14:8]));
      chk("flag bits", 16'h0080, rd_data & 16'h8080);
      run(ECD_CMD_SYN_DATA, 16'h0000, 16'h00F6);
      chk("flag bits", 16'h0080, rd_data & 16'h8080);
      run(ECD_CMD_DATA_SYN, 16'hFFFF, 16'h00F2);
      run(ECD_CMD_INJECT, 16'hC3FF, 16'h00F2);
      chk("inject word", 16'hA55A, mem_r);
      run(ECD_CMD_CLEAR, 16'h0000, 16'h00F7);
      chk("syn latch", 16'h0000, 16'(dev_u.sil_r));
      close_out();
   end
endmodule
`default_nettype wire
